// ---- lcd_memory_and_bias_control.sv ----
// Memory control and bias voltage control registers of the segment LCD controller
// Overview of operation
// - Writing one to bit 2 wipes all blink memory, then bit self-clears.
// - In mux mode 5 or more, bit 2 does nothing and clears at once.
// - Writing one to bit 1 wipes all display memory, then bit self-clears.
// - Display-source bit is software writable only in blink mode 00.
// - Display-source bit held zero in blink modes 01, 10 or mux 5 and up.
// - In blink mode 11 display-source bit is read-only, tracks shown memory.
// - Returning blink mode to 00 clears the display-source bit.
// - Display-source 0 shows display memory, 1 shows blink memory.
// - Pump clock is source divided by field plus one, then by eight.
// - Voltage code applies only with pump enable and reference enable set.
// - Pump runs only if enabled, bias internal and code nonzero.
// - Bit 6 enables the internal reference on the top bias pin.
// - Bit 5 picks external supply or core supply for the highest bias pin.
// - Bit 0 selects static or switched top bias reference.
// - Blink mode 00 off, 01 per segment, 10 all, 11 alternating memories.
// - Mux above 5 suppresses per-segment and alternating blinking.
`timescale 1ns/1ps
module lcd_memory_and_bias_control
  import lcd_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [lcd_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [lcd_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [lcd_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] blink_mode_field,
  input wire logic [2:0] mux_mode,
  input wire logic blink_phase,
  input wire logic lf_clk_en,
  input wire logic external_bias_select,
  output logic display_source_select,
  output logic blink_enable,
  output logic display_mem_wipe_en,
  output logic blink_mem_wipe_en,
  output logic [lcd_ctrl_pkg::MEM_IDX_W-1:0] wipe_idx,
  output logic pump_clk_en,
  output logic pump_run,
  output logic [3:0] ref_voltage_code,
  output logic ref_enable,
  output logic top_bias_supply_select,
  output logic ref_switch_mode
);
  logic [3:0] cpf_q;
  logic [3:0] vcode_q;
  logic cpen_q;
  logic refen_q;
  logic selvdd_q;
  logic refmode_q;
  logic disp_q;
  logic clrm_q;
  logic clrbm_q;
  logic [1:0] blk_prev_q;
  logic [3:0] pre_cnt_q;
  logic [3:0] post_cnt_q;
  logic wr_mem;
  logic wr_vctl;
  logic mux_hi;
  logic wiper_busy;
  logic wiper_en;
  logic wiper_start;
  logic [MEM_IDX_W-1:0] wiper_idx;
  logic [DATA_W-1:0] rd_d;

  assign wr_mem = wr_en && addr == MEMCTL_ADDR;
  assign wr_vctl = wr_en && addr == VCTL_ADDR;
  assign mux_hi = mux_mode >= MUX_BLINK_OFF;
  // Only one shared wiper: display and blink clears started together run in one pass
  assign wiper_start = wr_mem && (wdata[CLRM_BIT] || (wdata[CLRBM_BIT] && !mux_hi));

  lcd_mem_wiper u_wiper (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(wiper_start && !clrm_q && !clrbm_q),
    .busy(wiper_busy),
    .wipe_en(wiper_en),
    .wipe_idx(wiper_idx)
  );

  // Clear bits stand while the wipe runs and drop when it ends
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clrm_q <= 1'b0;
      clrbm_q <= 1'b0;
    end
    else if (wr_mem && !clrm_q && !clrbm_q)
    begin
      clrm_q <= wdata[CLRM_BIT];
      clrbm_q <= wdata[CLRBM_BIT] && !mux_hi;
    end
    else if (!wiper_busy)
    begin
      clrm_q <= 1'b0;
      clrbm_q <= 1'b0;
    end
  end

  // Display source select
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      disp_q <= 1'b0;
    else if (mux_hi || blink_mode_field == BLK_SEG || blink_mode_field == BLK_ALL)
      disp_q <= 1'b0;
    else if (blink_mode_field == BLK_ALT)
      disp_q <= blink_phase;
    else if (blk_prev_q != BLK_OFF)
      disp_q <= 1'b0;
    else if (wr_mem)
      disp_q <= wdata[DISP_BIT];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      blk_prev_q <= BLK_OFF;
    else
      blk_prev_q <= blink_mode_field;
  end

  // Voltage control register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpf_q <= CODE_ZERO;
      vcode_q <= CODE_ZERO;
      cpen_q <= 1'b0;
      refen_q <= 1'b0;
      selvdd_q <= 1'b0;
      refmode_q <= 1'b0;
    end
    else if (wr_vctl)
    begin
      cpf_q <= wdata[CPF_LSB +: 4];
      vcode_q <= wdata[VCODE_LSB +: 4];
      cpen_q <= wdata[CPEN_BIT];
      refen_q <= wdata[REFEN_BIT];
      selvdd_q <= wdata[SELVDD_BIT];
      refmode_q <= wdata[REFMODE_BIT];
    end
  end

  // Pump clock: divide by field plus one, then by eight
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_cnt_q <= CODE_ZERO;
      post_cnt_q <= CODE_ZERO;
      pump_clk_en <= 1'b0;
    end
    else
    begin
      pump_clk_en <= 1'b0;
      if (lf_clk_en)
      begin
        if (pre_cnt_q >= cpf_q)
        begin
          pre_cnt_q <= CODE_ZERO;
          if (post_cnt_q == POST_DIV_LAST)
          begin
            post_cnt_q <= CODE_ZERO;
            pump_clk_en <= 1'b1;
          end
          else
            post_cnt_q <= post_cnt_q + 1'b1;
        end
        else
          pre_cnt_q <= pre_cnt_q + 1'b1;
      end
    end
  end

  // Bias outputs
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pump_run <= 1'b0;
      ref_voltage_code <= CODE_ZERO;
      ref_enable <= 1'b0;
      top_bias_supply_select <= 1'b0;
      ref_switch_mode <= 1'b0;
    end
    else
    begin
      pump_run <= cpen_q && !external_bias_select && vcode_q != CODE_ZERO;
      ref_voltage_code <= (cpen_q && refen_q) ? vcode_q : CODE_ZERO;
      ref_enable <= refen_q;
      top_bias_supply_select <= selvdd_q;
      ref_switch_mode <= refmode_q;
    end
  end

  // Display outputs
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      display_source_select <= 1'b0;
      blink_enable <= 1'b0;
    end
    else
    begin
      display_source_select <= disp_q;
      blink_enable <= blink_mode_field == BLK_ALL ||
        ((blink_mode_field == BLK_SEG || blink_mode_field == BLK_ALT) && mux_mode <= MUX_BLINK_OFF);
    end
  end

  // Wipe strobes, index kept in step with the strobes
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      display_mem_wipe_en <= 1'b0;
      blink_mem_wipe_en <= 1'b0;
      wipe_idx <= '0;
    end
    else
    begin
      display_mem_wipe_en <= wiper_en && clrm_q;
      blink_mem_wipe_en <= wiper_en && clrbm_q;
      wipe_idx <= wiper_idx;
    end
  end

  // Read mux, reserved bits read zero
  always_comb
  begin
    rd_d = REG_RESET;
    if (addr == MEMCTL_ADDR)
    begin
      rd_d[DISP_BIT] = disp_q;
      rd_d[CLRM_BIT] = clrm_q;
      rd_d[CLRBM_BIT] = clrbm_q;
    end
    else if (addr == VCTL_ADDR)
    begin
      rd_d[CPF_LSB +: 4] = cpf_q;
      rd_d[VCODE_LSB +: 4] = vcode_q;
      rd_d[CPEN_BIT] = cpen_q;
      rd_d[REFEN_BIT] = refen_q;
      rd_d[SELVDD_BIT] = selvdd_q;
      rd_d[REFMODE_BIT] = refmode_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= REG_RESET;
    else if (rd_en)
      rdata <= rd_d;
    else
      rdata <= REG_RESET;
  end

  AST_CLRBM_MUXHI: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_mem && mux_hi && !clrm_q && !clrbm_q) |=> !clrbm_q) else $error("blink clear set in high mux");
  AST_CLRM_ENDS: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(clrm_q) |-> ##[1:22] !clrm_q) else $error("display clear never ends");
  AST_CLRBM_ENDS: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(clrbm_q) |-> ##[1:22] !clrbm_q) else $error("blink clear never ends");
  AST_DISP_HELD: assert property (@(posedge ref_clk) disable iff (!resetn)
    (blink_mode_field == BLK_ALL) |=> !disp_q) else $error("display source not held low");
  AST_DISP_TRACK: assert property (@(posedge ref_clk) disable iff (!resetn)
    (blink_mode_field == BLK_ALT && !mux_hi) |=> disp_q == $past(blink_phase)) else $error("source not tracking");
  AST_PUMP_GATE: assert property (@(posedge ref_clk) disable iff (!resetn)
    pump_run |-> $past(cpen_q) && $past(vcode_q) != CODE_ZERO) else $error("pump runs without cause");
  AST_CODE_GATE: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(cpen_q && refen_q) |=> ref_voltage_code == CODE_ZERO) else $error("voltage code leaks");
  AST_PUMP_SPACING: assert property (@(posedge ref_clk) disable iff (!resetn)
    pump_clk_en |=> !pump_clk_en) else $error("pump clock pulses back to back");
  AST_DISP_MUXHI: assert property (@(posedge ref_clk) disable iff (!resetn)
    mux_hi |=> !disp_q) else $error("display source set in high mux");
  AST_DISP_SEG: assert property (@(posedge ref_clk) disable iff (!resetn)
    (blink_mode_field == BLK_SEG) |=> !disp_q) else $error("display source set in segment blink");
  AST_DISP_RETURN: assert property (@(posedge ref_clk) disable iff (!resetn)
    (blink_mode_field == BLK_OFF && blk_prev_q != BLK_OFF) |=> !disp_q) else $error("source kept on return");
  AST_DISP_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_mem && blink_mode_field == BLK_OFF && blk_prev_q == BLK_OFF && !mux_hi) |=>
    disp_q == $past(wdata[DISP_BIT])) else $error("display source write lost");
  AST_DISP_OUT: assert property (@(posedge ref_clk) disable iff (!resetn)
    disp_q |=> display_source_select) else $error("display source output lags");
  AST_BLINK_SUPPRESS: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((blink_mode_field == BLK_SEG || blink_mode_field == BLK_ALT) && mux_mode > MUX_BLINK_OFF) |=>
    !blink_enable) else $error("blink not suppressed in high mux");
  AST_BLINK_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
    (blink_mode_field == BLK_OFF) |=> !blink_enable) else $error("blink on with mode off");
  AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
    !rd_en |=> rdata == REG_RESET) else $error("read data outside read cycle");
  AST_MEMCTL_RESERVED: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_en && addr == MEMCTL_ADDR) |=> rdata[DATA_W-1:CLRBM_BIT+1] == '0) else $error("reserved bits set");
  AST_PUMP_EXT: assert property (@(posedge ref_clk) disable iff (!resetn)
    external_bias_select |=> !pump_run) else $error("pump runs with external bias");
  AST_CODE_PASS: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cpen_q && refen_q) |=> ref_voltage_code == $past(vcode_q)) else $error("voltage code not applied");
  AST_WIPE_GATE: assert property (@(posedge ref_clk) disable iff (!resetn)
    display_mem_wipe_en |-> $past(clrm_q)) else $error("display wipe without clear");
endmodule // lcd_memory_and_bias_control

// ---- lcd_ctrl_pkg.sv ----
// Constants for the LCD memory and bias control block
package lcd_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] MEMCTL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] VCTL_ADDR = 4'h2;
  localparam int DISP_BIT = 0;
  localparam int CLRM_BIT = 1;
  localparam int CLRBM_BIT = 2;
  localparam int REFMODE_BIT = 0;
  localparam int SELVDD_BIT = 5;
  localparam int REFEN_BIT = 6;
  localparam int CPEN_BIT = 7;
  localparam int VCODE_LSB = 8;
  localparam int CPF_LSB = 12;
  localparam int MEM_WORDS = 20;
  localparam int MEM_IDX_W = 5;
  localparam logic [MEM_IDX_W-1:0] MEM_LAST = 5'h13;
  localparam logic [3:0] POST_DIV_LAST = 4'h7;
  localparam logic [2:0] MUX_BLINK_OFF = 3'h5;
  localparam logic [1:0] BLK_OFF = 2'h0;
  localparam logic [1:0] BLK_SEG = 2'h1;
  localparam logic [1:0] BLK_ALL = 2'h2;
  localparam logic [1:0] BLK_ALT = 2'h3;
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
endpackage

// ---- lcd_mem_wiper.sv ----
// Walks every memory word index once to clear it
`timescale 1ns/1ps
module lcd_mem_wiper
  import lcd_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  output logic busy,
  output logic wipe_en,
  output logic [lcd_ctrl_pkg::MEM_IDX_W-1:0] wipe_idx
);
  logic [MEM_IDX_W-1:0] idx_q;
  logic busy_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q <= 1'b0;
      idx_q <= '0;
    end
    else if (busy_q)
    begin
      if (idx_q == MEM_LAST)
      begin
        busy_q <= 1'b0;
        idx_q <= '0;
      end
      else
        idx_q <= idx_q + 1'b1;
    end
    else if (start)
    begin
      busy_q <= 1'b1;
      idx_q <= '0;
    end
  end

  assign busy = busy_q | start;
  assign wipe_en = busy_q;
  assign wipe_idx = idx_q;
endmodule // lcd_mem_wiper

// ---- test_lcd_memory_and_bias_control.sv ----
// Self-checking bench for the LCD memory and bias control registers
`timescale 1ns/1ps
module test_lcd_memory_and_bias_control;
  import lcd_ctrl_pkg::*;
  logic ref_clk, resetn, wr_en, rd_en, blink_phase, lf_clk_en, external_bias_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] blink_mode_field;
  logic [2:0] mux_mode;
  logic display_source_select, blink_enable, dwipe, bwipe, pump_clk_en, pump_run;
  logic ref_enable, top_bias_supply_select, ref_switch_mode;
  logic [MEM_IDX_W-1:0] wipe_idx;
  logic [3:0] ref_voltage_code;
  int error_cnt = 0, n_checks = 0, dw = 0, bw = 0, pc = 0, ws = 0;
  logic [1:0] tmode [6] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
  logic [2:0] tmux [6] = '{3'h6, 3'h5, 3'h7, 3'h6, 3'h0, 3'h0};
  logic [5:0] texp = 6'h15;

  lcd_memory_and_bias_control u_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .blink_mode_field(blink_mode_field), .mux_mode(mux_mode),
    .blink_phase(blink_phase), .lf_clk_en(lf_clk_en), .external_bias_select(external_bias_select),
    .display_source_select(display_source_select), .blink_enable(blink_enable),
    .display_mem_wipe_en(dwipe), .blink_mem_wipe_en(bwipe), .wipe_idx(wipe_idx),
    .pump_clk_en(pump_clk_en), .pump_run(pump_run), .ref_voltage_code(ref_voltage_code),
    .ref_enable(ref_enable), .top_bias_supply_select(top_bias_supply_select),
    .ref_switch_mode(ref_switch_mode));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Count wipe strobes and pump pulses seen at each edge
  always @(posedge ref_clk)
  begin
    dw += (dwipe === 1'b1);
    bw += (bwipe === 1'b1);
    pc += (pump_clk_en === 1'b1);
    ws += (dwipe === 1'b1 || bwipe === 1'b1) ? int'(wipe_idx) : 0;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Mode inputs are levels; give the registered outputs time to follow
  task automatic sig(input logic [1:0] m, input logic [2:0] x, input logic p);
    @(posedge ref_clk);
    blink_mode_field <= m;
    mux_mode <= x;
    blink_phase <= p;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    resetn = 1'b0;
    {wr_en, rd_en, blink_phase, lf_clk_en, external_bias_select} = 5'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    blink_mode_field = 2'h0;
    mux_mode = 3'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(MEMCTL_ADDR, REG_RESET);
    rd(VCTL_ADDR, REG_RESET);
    wr(4'h4, 16'hFFFF);
    rd(4'h4, 16'h0000);
    // Divider starts from zero, so 32 source pulses give exactly two pump pulses
    wr(VCTL_ADDR, 16'h1000);
    pc = 0;
    repeat (32)
    begin
      @(posedge ref_clk) lf_clk_en <= 1'b1;
      @(posedge ref_clk) lf_clk_en <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    chk(16'(pc), 16'h0002);
    wr(VCTL_ADDR, 16'hFFFF);
    rd(VCTL_ADDR, 16'hFFE1);
    chk(16'(ref_voltage_code), 16'h000F);
    chk(16'(ref_enable), 16'h0001);
    chk(16'(top_bias_supply_select), 16'h0001);
    chk(16'(ref_switch_mode), 16'h0001);
    chk(16'(pump_run), 16'h0001);
    @(posedge ref_clk) external_bias_select <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(16'(pump_run), 16'h0000);
    @(posedge ref_clk) external_bias_select <= 1'b0;
    wr(VCTL_ADDR, 16'h00E0);
    rd(VCTL_ADDR, 16'h00E0);
    chk(16'(pump_run), 16'h0000);
    chk(16'(ref_switch_mode), 16'h0000);
    wr(VCTL_ADDR, 16'h0F80);
    rd(VCTL_ADDR, 16'h0F80);
    chk(16'(ref_voltage_code), 16'h0000);
    chk(16'(ref_enable), 16'h0000);
    chk(16'(top_bias_supply_select), 16'h0000);
    for (int b = CLRM_BIT; b <= CLRBM_BIT; b++)
    begin
      dw = 0;
      bw = 0;
      ws = 0;
      wr(MEMCTL_ADDR, 16'(1 << b));
      rd(MEMCTL_ADDR, 16'(1 << b));
      repeat (25) @(posedge ref_clk);
      rd(MEMCTL_ADDR, 16'h0000);
      chk(16'(dw), (b == CLRM_BIT) ? 16'(MEM_WORDS) : 16'h0000);
      chk(16'(bw), (b == CLRBM_BIT) ? 16'(MEM_WORDS) : 16'h0000);
      // Every word index from zero to the last must be strobed exactly once
      chk(16'(ws), 16'(MEM_WORDS * (MEM_WORDS - 1) / 2));
    end
    sig(2'h0, 3'h5, 1'b0);
    bw = 0;
    wr(MEMCTL_ADDR, 16'h0004);
    rd(MEMCTL_ADDR, 16'h0000);
    repeat (25) @(posedge ref_clk);
    chk(16'(bw), 16'h0000);
    wr(MEMCTL_ADDR, 16'h0001);
    rd(MEMCTL_ADDR, 16'h0000);
    sig(2'h0, 3'h0, 1'b0);
    wr(MEMCTL_ADDR, 16'h0001);
    rd(MEMCTL_ADDR, 16'h0001);
    chk(16'(display_source_select), 16'h0001);
    sig(2'h1, 3'h0, 1'b0);
    rd(MEMCTL_ADDR, 16'h0000);
    wr(MEMCTL_ADDR, 16'h0001);
    rd(MEMCTL_ADDR, 16'h0000);
    sig(2'h2, 3'h0, 1'b0);
    wr(MEMCTL_ADDR, 16'h0001);
    rd(MEMCTL_ADDR, 16'h0000);
    sig(2'h3, 3'h0, 1'b1);
    rd(MEMCTL_ADDR, 16'h0001);
    chk(16'(display_source_select), 16'h0001);
    wr(MEMCTL_ADDR, 16'h0000);
    rd(MEMCTL_ADDR, 16'h0001);
    sig(2'h3, 3'h0, 1'b0);
    rd(MEMCTL_ADDR, 16'h0000);
    sig(2'h3, 3'h0, 1'b1);
    sig(2'h0, 3'h0, 1'b1);
    rd(MEMCTL_ADDR, 16'h0000);
    chk(16'(display_source_select), 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      sig(tmode[i], tmux[i], 1'b0);
      chk(16'(blink_enable), 16'(texp[5-i]));
    end
    tally_and_finish();
  end
endmodule // test_lcd_memory_and_bias_control
